// ---- core/atc_conv.sv ----
`timescale 1ns/1ps
`include "atc_map.svh"

module atc_conv (
	// Clock and reset.
	input wire logic mclk,
	input wire logic reset,
	// Control.
	input wire logic start,
	input wire logic temp_mode,
	input wire logic [7:0] tv_offset,
	output logic busy,
	output logic done_pulse,
	output logic [7:0] code,
	// Analog converter core.
	output logic ana_start,
	input wire logic ana_done,
	input wire logic [7:0] ana_code
);
	import atc_pkg::*;

	localparam logic [3:0] SETTLE_LAST = 4'(`ATC_SETTLE_CYC - 1);

	atc_state_t state;
	logic [3:0] cnt;
	logic signed [9:0] sum;
	logic [7:0] adjusted;

	assign sum = $signed({2'b00, ana_code}) +
		$signed({{2{tv_offset[7]}}, tv_offset});
	// Saturate so a large offset cannot wrap a cold reading to hot.
	assign adjusted = sum[9] ? 8'h00 : (sum[8] ? 8'hff : sum[7:0]);
	assign busy = (state != st_idle);

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			state <= st_idle;
			cnt <= 4'h0;
			ana_start <= 1'b0;
			done_pulse <= 1'b0;
			code <= `ATC_RST_RES;
		end else begin
			ana_start <= 1'b0;
			done_pulse <= 1'b0;
			case (state)
			st_idle: begin
				cnt <= 4'h0;
				if (start) begin
					state <= st_settle;
				end
			end
			st_settle: begin
				cnt <= cnt + 4'h1;
				if (cnt == SETTLE_LAST) begin
					state <= st_wait;
					ana_start <= 1'b1;
				end
			end
			st_wait: begin
				if (ana_done) begin
					state <= st_idle;
					done_pulse <= 1'b1;
					code <= temp_mode ? adjusted : ana_code;
				end
			end
			default: begin
				state <= st_idle;
			end
			endcase
		end
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (reset);

	raw_passthrough_a: assert property (
		(state == st_wait && ana_done && !temp_mode)
		|=> (code == $past(ana_code)))
		else $error("non-temperature result was altered");

	settle_time_a: assert property (
		(state == st_idle && start) |=> !ana_start [*8] ##1 ana_start)
		else $error("sample request not issued after settling");

endmodule // atc_conv

// ---- core/atc_top.sv ----
// Functional notes
// - Writing one to config bit 7 starts a measurement; reading bit 7 returns one once it has finished.
// - Source code 000 routes the temperature sensor, 001 to 011 route pins 0 to 2 single-ended.
// - Codes 100, 101, 110 pick pairs 0-1, 1-2, 0-2 differential and 111 grounds the input.
// - Reference is the bandgap when the upper select bit is zero, a third of supply for 10, half for 11.
// - The 2-bit gain sets differential full range as (gain + 1) times a step set by the low reference bit.
// - The amplifier offset is a 4-bit sign-magnitude field resetting to zero, upper bits read zero.
// - The result register is read-only and shows the latest conversion value.
// - The 2-bit range field picks the temperature scale mapping of one result step.
// - Calibration bit 5 enables the Kelvin to Celsius offset; the register resets to 0x20.
// - Calibration bit 4 enables applying the 4-bit trim in bits 3 to 0.
// - The signed temperature offset is added to each measured temperature value.
//
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "atc_map.svh"

module atc_top (
	// Clock and reset.
	input wire logic mclk,
	input wire logic reset,
	// AHB-Lite slave.
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Analog front end.
	output atc_pkg::atc_src_t ana_src,
	output logic ana_tsensor_en,
	output logic ana_diff,
	output logic ana_gnd,
	output logic ana_ref_bg,
	output logic ana_ref_third,
	output logic ana_ref_half,
	output logic [1:0] ana_gain,
	output logic ana_fs_step_hi,
	output logic ana_offs_neg,
	output logic [2:0] ana_offs_mag,
	// Temperature sensor.
	output logic [1:0] ts_range,
	output logic ts_koffs_en,
	output logic ts_trim_en,
	output logic [3:0] ts_trim,
	// Converter core handshake.
	output logic ana_start,
	input wire logic ana_done,
	input wire logic [7:0] ana_code
);
	import atc_pkg::*;

	// Bus state.
	logic a_valid;
	logic a_write;
	logic [7:0] a_idx;
	logic rd_wait;
	// Register fields.
	atc_src_t cfg_sel;
	logic [1:0] cfg_ref;
	logic [1:0] cfg_gain;
	logic [3:0] amp_offs;
	logic [7:0] cal;
	logic [7:0] tvo;
	logic [7:0] result;
	logic done;
	// Converter engine.
	logic conv_busy;
	logic conv_done;
	logic [7:0] conv_code;

	wire take = hsel && htrans[1] && hready;
	wire take_rd = take && !hwrite;
	wire [7:0] req_idx = haddr[9:2];
	wire wr_go = a_valid && a_write;
	wire wr_cfg = wr_go && (a_idx == `ATC_IDX_CFG);
	wire wr_amp = wr_go && (a_idx == `ATC_IDX_AMP);
	wire wr_cal = wr_go && (a_idx == `ATC_IDX_CAL);
	wire wr_tvo = wr_go && (a_idx == `ATC_IDX_TVO);
	wire conv_start = wr_cfg && hwdata[`ATC_CFG_START] &&
		!conv_busy && !conv_done;
	wire [7:0] cfg_word = {done, cfg_sel, cfg_ref, cfg_gain};
	wire [7:0] rd_byte =
		(a_idx == `ATC_IDX_CFG) ? cfg_word :
		(a_idx == `ATC_IDX_AMP) ? {4'h0, amp_offs} :
		(a_idx == `ATC_IDX_RES) ? result :
		(a_idx == `ATC_IDX_CAL) ? cal :
		(a_idx == `ATC_IDX_TVO) ? tvo : 8'h00;
	wire is_temp = (cfg_sel == `ATC_SRC_TEMP);
	wire is_diff = (cfg_sel >= `ATC_SRC_DIFF01) &&
		(cfg_sel <= `ATC_SRC_DIFF02);

	// Reads take one wait state so that a write just ahead is visible.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			a_valid <= 1'b0;
			a_write <= 1'b0;
			a_idx <= 8'h00;
			rd_wait <= 1'b0;
			hreadyout <= 1'b1;
			hrdata <= 32'h0;
		end else begin
			if (hready) begin
				a_valid <= take;
				a_write <= hwrite;
				a_idx <= req_idx;
			end
			rd_wait <= take_rd;
			hreadyout <= !take_rd;
			if (rd_wait) begin
				hrdata <= {24'h0, rd_byte};
			end
		end
	end

	assign hresp = 1'b0;

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			cfg_sel <= `ATC_RST_SEL;
			cfg_ref <= `ATC_RST_REF;
			cfg_gain <= `ATC_RST_GAIN;
			amp_offs <= `ATC_RST_AMP;
			cal <= `ATC_RST_CAL;
			tvo <= `ATC_RST_TVO;
		end else begin
			if (wr_cfg) begin
				cfg_sel <= hwdata[`ATC_CFG_SEL_HI:`ATC_CFG_SEL_LO];
				cfg_ref <= hwdata[`ATC_CFG_REF_HI:`ATC_CFG_REF_LO];
				cfg_gain <= hwdata[`ATC_CFG_GAIN_HI:`ATC_CFG_GAIN_LO];
			end
			if (wr_amp) begin
				amp_offs <= hwdata[3:0];
			end
			if (wr_cal) begin
				cal <= hwdata[7:0];
			end
			if (wr_tvo) begin
				tvo <= hwdata[7:0];
			end
		end
	end

	// A start is refused while busy and in the completion cycle, so
	// the set and the clear of the done flag never meet.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			done <= 1'b0;
			result <= `ATC_RST_RES;
		end else begin
			if (conv_done) begin
				done <= 1'b1;
				result <= conv_code;
			end else if (conv_start) begin
				done <= 1'b0;
			end
		end
	end

	// Front-end controls are registered so every output is a flop.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			ana_src <= `ATC_RST_SEL;
			ana_tsensor_en <= 1'b1;
			ana_diff <= 1'b0;
			ana_gnd <= 1'b0;
			ana_ref_bg <= 1'b1;
			ana_ref_third <= 1'b0;
			ana_ref_half <= 1'b0;
			ana_gain <= `ATC_RST_GAIN;
			ana_fs_step_hi <= 1'b0;
			ana_offs_neg <= 1'b0;
			ana_offs_mag <= 3'h0;
			ts_range <= 2'h0;
			ts_koffs_en <= 1'b1;
			ts_trim_en <= 1'b0;
			ts_trim <= 4'h0;
		end else begin
			ana_src <= cfg_sel;
			ana_tsensor_en <= is_temp;
			ana_diff <= is_diff;
			ana_gnd <= (cfg_sel == `ATC_SRC_GND);
			ana_ref_bg <= !cfg_ref[1];
			ana_ref_third <= (cfg_ref == 2'h2);
			ana_ref_half <= (cfg_ref == 2'h3);
			ana_gain <= cfg_gain;
			ana_fs_step_hi <= cfg_ref[0];
			ana_offs_neg <= amp_offs[`ATC_AMP_SIGN];
			ana_offs_mag <= amp_offs[2:0];
			ts_range <= cal[`ATC_CAL_RANGE_HI:`ATC_CAL_RANGE_LO];
			ts_koffs_en <= cal[`ATC_CAL_KOFFS];
			ts_trim_en <= cal[`ATC_CAL_TRIMEN];
			ts_trim <= cal[3:0];
		end
	end

	atc_conv u_conv (
		.mclk(mclk),
		.reset(reset),
		.start(conv_start),
		.temp_mode(is_temp),
		.tv_offset(tvo),
		.busy(conv_busy),
		.done_pulse(conv_done),
		.code(conv_code),
		.ana_start(ana_start),
		.ana_done(ana_done),
		.ana_code(ana_code)
	);

	default clocking @(posedge mclk); endclocking
	default disable iff (reset);

	sequence rd_of(logic [7:0] idx);
		take_rd && (req_idx == idx);
	endsequence

	sequence answer_now;
		!hreadyout ##1 hreadyout;
	endsequence

	start_clears_done_a: assert property (
		conv_start |=> !done)
		else $error("done flag not cleared by start");

	done_sets_flag_a: assert property (
		conv_done |=> done && result == $past(conv_code))
		else $error("completion did not set flag and result");

	result_hold_a: assert property (
		!conv_done |=> $stable(result))
		else $error("result changed without completion");

	cfg_done_read_a: assert property (
		rd_of(`ATC_IDX_CFG) ##0 (!conv_done && !conv_start)[*2]
		|-> answer_now ##0 (hrdata[7] == done))
		else $error("config read does not show done flag");

	amp_read_a: assert property (
		rd_of(`ATC_IDX_AMP) |=> answer_now ##0 (hrdata[31:4] == 28'h0))
		else $error("amplifier offset upper bits not zero");

	temp_route_a: assert property (
		is_temp |=> ana_tsensor_en && !ana_diff && !ana_gnd)
		else $error("temperature sensor not routed");

	diff_route_a: assert property (
		is_diff |=> ana_diff && !ana_gnd && !ana_tsensor_en)
		else $error("differential pair not selected");

	gnd_route_a: assert property (
		(cfg_sel == `ATC_SRC_GND) |=> ana_gnd && !ana_diff)
		else $error("ground source not selected");

	ref_pick_a: assert property (
		1'b1 |=> (ana_ref_bg != $past(cfg_ref[1])) &&
		(ana_ref_half == ($past(cfg_ref) == 2'h3)))
		else $error("reference selection wrong");

	gain_step_a: assert property (
		1'b1 |=> ana_gain == $past(cfg_gain) &&
		ana_fs_step_hi == $past(cfg_ref[0]))
		else $error("gain or step mismatch");

	cal_fields_a: assert property (
		1'b1 |=> ts_koffs_en == $past(cal[5]) &&
		ts_trim_en == $past(cal[4]) && ts_range == $past(cal[7:6]))
		else $error("calibration controls mismatch");

	trim_value_a: assert property (
		1'b1 |=> ts_trim == $past(cal[3:0]))
		else $error("trim value not passed to sensor");

	offs_split_a: assert property (
		1'b1 |=> ana_offs_neg == $past(amp_offs[3]) &&
		ana_offs_mag == $past(amp_offs[2:0]))
		else $error("amplifier offset sign or magnitude wrong");

	ref_third_a: assert property (
		1'b1 |=> ana_ref_third == ($past(cfg_ref) == 2'h2))
		else $error("third of supply reference wrong");

	amp_write_a: assert property (
		wr_amp |=> amp_offs == $past(hwdata[3:0]))
		else $error("amplifier offset write lost");

	cal_write_a: assert property (
		wr_cal |=> cal == $past(hwdata[7:0]))
		else $error("calibration write lost");

	result_read_a: assert property (
		rd_of(`ATC_IDX_RES) ##0 (!conv_done)[*2]
		|-> answer_now ##0 (hrdata[7:0] == result))
		else $error("result read does not show result");

endmodule // atc_top

// ---- pkg/atc_map.svh ----
`ifndef ATC_MAP_SVH
`define ATC_MAP_SVH

// Register word indices; the byte address is four times the index.
`define ATC_IDX_CFG 8'h0f
`define ATC_IDX_AMP 8'h10
`define ATC_IDX_RES 8'h11
`define ATC_IDX_CAL 8'h12
`define ATC_IDX_TVO 8'h13

// Field positions.
`define ATC_CFG_START 7
`define ATC_CFG_SEL_HI 6
`define ATC_CFG_SEL_LO 4
`define ATC_CFG_REF_HI 3
`define ATC_CFG_REF_LO 2
`define ATC_CFG_GAIN_HI 1
`define ATC_CFG_GAIN_LO 0
`define ATC_AMP_SIGN 3
`define ATC_CAL_RANGE_HI 7
`define ATC_CAL_RANGE_LO 6
`define ATC_CAL_KOFFS 5
`define ATC_CAL_TRIMEN 4

// Reset values.
`define ATC_RST_SEL 3'h0
`define ATC_RST_REF 2'h0
`define ATC_RST_GAIN 2'h0
`define ATC_RST_AMP 4'h0
`define ATC_RST_CAL 8'h20
`define ATC_RST_TVO 8'h00
`define ATC_RST_RES 8'h00

// Input source codes.
`define ATC_SRC_TEMP 3'h0
`define ATC_SRC_DIFF01 3'h4
`define ATC_SRC_DIFF02 3'h6
`define ATC_SRC_GND 3'h7

// Input settling time before a sample is requested, and its cycle count.
`define ATC_CLK_PERIOD_NS 8
`define ATC_SETTLE_NS 64
`define ATC_SETTLE_CYC \
	((`ATC_SETTLE_NS + `ATC_CLK_PERIOD_NS - 1) / `ATC_CLK_PERIOD_NS)

`endif

// ---- pkg/atc_pkg.sv ----
package atc_pkg;

	typedef logic [2:0] atc_src_t;

	typedef enum logic [2:0] {
		st_idle = 3'b001,
		st_settle = 3'b010,
		st_wait = 3'b100
	} atc_state_t;

endpackage

// ---- sim/atc_tb.sv ----
`timescale 1ns/1ps
`include "atc_map.svh"

module testbench;
	import atc_pkg::*;
	logic mclk, reset, hsel, hwrite, ana_done, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rv;
	logic [1:0] htrans, ana_gain, ts_range;
	logic [2:0] hsize, ana_offs_mag;
	logic ana_tsensor_en, ana_diff, ana_gnd, ana_ref_bg, ana_ref_third;
	logic ana_ref_half, ana_fs_step_hi, ana_offs_neg, ts_koffs_en;
	logic ts_trim_en, ana_start;
	logic [3:0] ts_trim;
	logic [7:0] ana_code, last;
	atc_src_t ana_src;
	int n_fail = 0;
	int check_count = 0;
	int cyc = 0;
	int st = 0;
	int pulses = 0;
	int t0, p0;
	logic [7:0] mt [4][4] = '{'{8'h00, 8'hfe, 8'h50, 8'h4e},
		'{8'h0c, 8'h10, 8'hf8, 8'hff}, '{8'h00, 8'hfe, 8'h01, 8'h00},
		'{8'h4d, 8'hfe, 8'h33, 8'h33}};
	logic [7:0] pv [3] = '{8'hff, 8'h05, 8'h9f};

	atc_top DUT (.mclk(mclk), .reset(reset), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .ana_src(ana_src), .ana_tsensor_en(ana_tsensor_en),
		.ana_diff(ana_diff), .ana_gnd(ana_gnd), .ana_ref_bg(ana_ref_bg),
		.ana_ref_third(ana_ref_third), .ana_ref_half(ana_ref_half),
		.ana_gain(ana_gain), .ana_fs_step_hi(ana_fs_step_hi),
		.ana_offs_neg(ana_offs_neg), .ana_offs_mag(ana_offs_mag),
		.ts_range(ts_range), .ts_koffs_en(ts_koffs_en),
		.ts_trim_en(ts_trim_en), .ts_trim(ts_trim), .ana_start(ana_start),
		.ana_done(ana_done), .ana_code(ana_code));

	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	// Sample requests are counted so a start that is not refused shows as a second pulse.
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (ana_start === 1'b1) begin
			st <= cyc + 1;
			pulses <= pulses + 1;
		end
	end

	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task wrap_up;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task wait_rdy;
		int n;
		n = 0;
		@(posedge mclk);
		while (hreadyout !== 1'b1) begin
			n++;
			if (n > 20) begin
				n_fail++;
				$display("BAD %0t bus hang", $time);
				wrap_up;
			end
			@(posedge mclk);
		end
	endtask

	task xfer(input logic w, input logic [7:0] idx, input logic [31:0] d);
		@(posedge mclk);
		haddr <= {22'h0, idx, 2'b00};
		htrans <= 2'b10;
		hwrite <= w;
		wait_rdy;
		htrans <= 2'b00;
		hwdata <= d;
		wait_rdy;
		rv = hrdata;
	endtask

	task wr(input logic [7:0] idx, input logic [7:0] d);
		xfer(1'b1, idx, {24'hffffff, d});
	endtask

	task rd(input logic [7:0] idx, input logic [7:0] e, input string m);
		xfer(1'b0, idx, 32'h0);
		chk(rv, {24'h0, e}, m);
	endtask

	function automatic logic [11:0] exp_cfg(input logic [7:0] c);
		logic [2:0] s;
		logic [1:0] r;
		s = c[6:4];
		r = c[3:2];
		return {s, s == 3'h0, s >= 3'h4 && s <= 3'h6, s == 3'h7, ~r[1],
			r == 2'h2, r == 2'h3, c[1:0], r[0]};
	endfunction

	task meas(input logic [7:0] c, tv, raw, ex, input logic bw);
		int n;
		wr(`ATC_IDX_TVO, tv);
		p0 = pulses;
		wr(`ATC_IDX_CFG, {1'b1, c[6:0]});
		#1 t0 = cyc;
		rd(`ATC_IDX_CFG, {1'b0, c[6:0]}, "done kept");
		rd(`ATC_IDX_RES, last, "result early");
		// A second start while the core waits for the converter result must not restart the sequence.
		if (bw)
			wr(`ATC_IDX_CFG, {1'b1, c[6:0]});
		n = 0;
		while (pulses == p0) begin
			@(posedge mclk);
			#1 n++;
			if (n > 40) begin
				n_fail++;
				$display("BAD %0t no sample request", $time);
				wrap_up;
			end
		end
		chk(32'(st - t0), 32'(`ATC_SETTLE_CYC + 1), "settle");
		repeat (2) @(posedge mclk);
		ana_done <= 1'b1;
		ana_code <= raw;
		@(posedge mclk);
		ana_done <= 1'b0;
		ana_code <= ~raw;
		repeat (3) @(posedge mclk);
		rd(`ATC_IDX_CFG, {1'b1, c[6:0]}, "done flag");
		rd(`ATC_IDX_RES, ex, "result");
		chk(32'(pulses - p0), 32'h1, "pulse count");
		last = ex;
	endtask

	initial begin
		reset = 1'b1;
		hsel = 1'b1;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0;
		ana_done = 1'b0;
		ana_code = 8'h0;
		last = 8'h0;
		repeat (6) @(posedge mclk);
		reset <= 1'b0;
		#1 chk(32'({hreadyout, hresp, ts_koffs_en}), 32'h5, "rst out");
		rd(`ATC_IDX_CFG, 8'h00, "cfg rst");
		rd(`ATC_IDX_AMP, 8'h00, "amp rst");
		rd(`ATC_IDX_RES, 8'h00, "res rst");
		rd(`ATC_IDX_CAL, 8'h20, "cal rst");
		rd(`ATC_IDX_TVO, 8'h00, "tvo rst");
		// Pins are taken as already set to analog input.
		for (int i = 0; i < 8; i++) begin
			wr(`ATC_IDX_CFG, {1'b0, 3'(i), 2'(i), ~2'(i)});
			repeat (2) @(posedge mclk);
			#1 chk(32'({ana_src, ana_tsensor_en, ana_diff, ana_gnd,
				ana_ref_bg, ana_ref_third, ana_ref_half, ana_gain,
				ana_fs_step_hi}), 32'(exp_cfg({1'b0, 3'(i), 2'(i),
				~2'(i)})), "cfg pins");
			rd(`ATC_IDX_CFG, {1'b0, 3'(i), 2'(i), ~2'(i)}, "cfg rb");
		end
		for (int i = 0; i < 2; i++) begin
			wr(`ATC_IDX_AMP, pv[i]);
			rd(`ATC_IDX_AMP, {4'h0, pv[i][3:0]}, "amp rb");
			#1 chk(32'({ana_offs_neg, ana_offs_mag}), 32'(pv[i][3:0]), "amp");
		end
		wr(`ATC_IDX_CAL, pv[2]);
		rd(`ATC_IDX_CAL, pv[2], "cal rb");
		#1 chk(32'({ts_range, ts_koffs_en, ts_trim_en, ts_trim}), 32'h9f,
			"cal pins");
		wr(8'h20, 8'h55);
		rd(8'h20, 8'h00, "unmapped");
		// A completion outside a measurement must be ignored.
		@(posedge mclk);
		ana_done <= 1'b1;
		ana_code <= 8'h77;
		@(posedge mclk);
		ana_done <= 1'b0;
		rd(`ATC_IDX_RES, 8'h00, "stray done");
		for (int k = 0; k < 4; k++)
			meas(mt[k][0], mt[k][1], mt[k][2], mt[k][3], k == 1);
		wr(`ATC_IDX_RES, 8'haa);
		rd(`ATC_IDX_RES, last, "res ro");
		wrap_up;
	end
endmodule // testbench
